// File: bench/twcsp_chk.sv
`timescale 1ns/1ps
module twcsp_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // serial link wires
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic sdio_host_o,
    input wire logic sdio_host_oe,
    input wire logic sdio_dev_o,
    input wire logic sdio_dev_oe,
    input wire logic sdio
);
    logic sclk_q;
    logic [2:0] rise_cnt_q;
    ////////////////////////////////////////////////////////////////
    // rises modulo 8 inside frames; stalls keep the count, so it must sit on a byte edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_q <= 1'h0;
            rise_cnt_q <= 3'h0;
        end else begin
            sclk_q <= sclk;
            if (sclk && !sclk_q && !chip_select_n) begin
                rise_cnt_q <= rise_cnt_q + 3'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // link relations
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_NO_CONTENTION: assert property (!(sdio_host_oe && sdio_dev_oe))
        else $error("host and device drive the data line together");
    AST_DEV_QUIET: assert property (
        chip_select_n && $past(chip_select_n, 8) |-> !sdio_dev_oe)
        else $error("device drives while deselected");
    AST_DEV_HOLD: assert property (
        sclk && $past(sclk, 5) && sdio_dev_oe |-> $stable(sdio_dev_o))
        else $error("device data moved during clock high");
    AST_HOST_SETUP: assert property (
        $rose(sclk) && sdio_host_oe |-> $stable(sdio_host_o) ##1 $stable(sdio_host_o))
        else $error("host data not stable around clock rise");
    AST_SCLK_GATED: assert property ($changed(sclk) |-> !$past(chip_select_n))
        else $error("serial clock toggles while deselected");
    AST_FIRST_EDGE: assert property ($fell(chip_select_n) |-> !sclk [*8])
        else $error("clock rise too soon after select");
    // host keeps whole bytes, so the two ends never drift apart
    AST_BYTE_EDGE: assert property (
        $rose(chip_select_n) |-> rise_cnt_q == 3'h0)
        else $error("select raised inside a byte");
    AST_TURN_POINT: assert property (
        $rose(sdio_dev_oe) |-> rise_cnt_q == 3'h0 && !chip_select_n)
        else $error("device turned the line off a byte edge");
    AST_TURN_PROMPT: assert property (
        $fell(sdio_host_oe) && !chip_select_n |-> ##[1:6] sdio_dev_oe)
        else $error("device late taking the data line");
    // the resolved wire carries the device bit whenever it drives
    AST_LINE_OWNER: assert property (sdio_dev_oe |-> sdio == sdio_dev_o)
        else $error("data line does not carry the device bit");
    // main scenarios reached
    cover property ($rose(sdio_dev_oe));
    cover property ($fell(chip_select_n));
    cover property ($rose(chip_select_n) ##[1:60] $fell(chip_select_n));
endmodule

// File: bench/twcsp_tb.sv
`timescale 1ns/1ps
module twcsp_tb;
    import twcsp_pkg::*;
    // arbitrary identity value
    localparam logic [7:0] ID_VAL = 8'hC3;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, lsb_first, wr_stb, lsb_mode;
    logic [7:0] paddr, wr_data;
    logic [31:0] pwdata, prdata, rx;
    logic [15:0] act_index;
    logic [12:0] wr_addr;
    logic [12:0] cap_a[$];
    logic [7:0] cap_d[$];
    logic [2:0] stream_cnt;
    int n_mismatch, comparisons;
    ////////////////////////////////////////////////////////////////
    // the two ends face each other over one link
    twcsp_if twcsp_if_i();
    twcsp_host twcsp_host_i(.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(twcsp_if_i.host));
    twcsp_dev #(.CHIP_ID_VAL(ID_VAL)) twcsp_dev_i(.mclk(mclk), .rst(rst),
        .link(twcsp_if_i.dev), .lsb_first(lsb_first), .act_index(act_index),
        .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));
    twcsp_chk twcsp_chk_i(.mclk(mclk), .rst(rst), .sclk(twcsp_if_i.sclk),
        .chip_select_n(twcsp_if_i.chip_select_n), .sdio_host_o(twcsp_if_i.sdio_host_o),
        .sdio_host_oe(twcsp_if_i.sdio_host_oe), .sdio_dev_o(twcsp_if_i.sdio_dev_o),
        .sdio_dev_oe(twcsp_if_i.sdio_dev_oe), .sdio(twcsp_if_i.sdio));
    ////////////////////////////////////////////////////////////////
    // clock, write capture, watchdog
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (wr_stb === 1'h1) begin
            cap_a.push_back(wr_addr);
            cap_d.push_back(wr_data);
        end
    end
    initial begin
        // nearly three times the longest expected run
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////
    // helpers
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        r = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // full serial frame; polling is bounded so a dead link cannot hang
    task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] a,
                         input logic [31:0] tx, input logic stall, output logic [31:0] r);
        logic [31:0] st;
        int k;
        apb(1'h1, HREG_ADDR, {19'h0, a}, st);
        apb(1'h1, HREG_COUNT, {29'h0, stream_cnt}, st);
        apb(1'h1, HREG_TXD, tx, st);
        apb(1'h1, HREG_CTRL, {26'h0, lsb_mode, stall, len, rd, 1'h1}, st);
        k = 0;
        st = 32'h0;
        while (st[1] !== 1'h1 && k < 4000) begin
            apb(1'h0, HREG_STATUS, 32'h0, st);
            k++;
        end
        check({31'h0, st[1]}, 32'h1);
        apb(1'h0, HREG_RXD, 32'h0, r);
    endtask
    // address walks down in msb order, up in lsb order
    function automatic logic [12:0] exp_addr(input logic [12:0] a, input int k);
        return lsb_mode ? a + 13'(k) : a - 13'(k);
    endfunction
    // bytes a frame carries: the length code plus one, or the clamped stream count
    function automatic int exp_len(input logic [1:0] len, input logic [2:0] cnt);
        if (len != LEN_STREAM) begin
            return int'(len) + 1;
        end
        return (cnt == 3'h0) ? 1 : (cnt > 3'(STREAM_MAX)) ? STREAM_MAX : int'(cnt);
    endfunction
    // random write, captured bytes compared, then read back
    task automatic rw_check(input logic [1:0] len, input logic [12:0] a, input logic stall);
        logic [31:0] tx, r;
        int n;
        n = exp_len(len, stream_cnt);
        tx = $urandom;
        cap_a.delete();
        cap_d.delete();
        frame(1'h0, len, a, tx, stall, r);
        check(32'(cap_a.size()), 32'(n));
        for (int k = 0; k < n; k++) begin
            check(32'(cap_a[k]), 32'(exp_addr(a, k)));
            check(32'(cap_d[k]), 32'(tx[8*k+:8]));
        end
        // readback stalls too, so the resume turn of the line is exercised
        frame(1'h1, len, a, 32'h0, stall, r);
        for (int k = 0; k < n; k++) begin
            check(32'(r[8*k+:8]), 32'(tx[8*k+:8]));
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lsb_mode = 1'h0;
        stream_cnt = 3'h4;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(30));
        repeat (8) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        check(32'(act_index), 32'h0F0F);
        check(32'(lsb_first), 32'h0);
        // every length code unstalled, and every one but the stream stalled
        for (int i = 0; i < 8; i++) begin
            // corner stream counts: zero gives one byte, seven clamps to four
            stream_cnt = (i == 3) ? 3'h0 : 3'h7;
            rw_check(2'(i), 13'(10 + $urandom_range(0, 50)), i >= 4);
        end
        frame(1'h1, 2'h0, ADDR_CHIP_ID, 32'h0, 1'h0, rx);
        check(32'(rx[7:0]), 32'(ID_VAL));
        // shadowed index bytes move only on the transfer bit
        frame(1'h0, 2'h1, ADDR_INDEX_1, 32'h050A, 1'h1, rx);
        check(32'(act_index), 32'h0F0F);
        frame(1'h0, 2'h0, ADDR_XFER, 32'h1, 1'h0, rx);
        check(32'(act_index), 32'h050A);
        // mirrored order bits, then traffic lsb first
        frame(1'h0, 2'h0, ADDR_PORT_CFG, 32'h42, 1'h0, rx);
        check(32'(lsb_first), 32'h1);
        lsb_mode = 1'h1;
        for (int i = 0; i < 4; i++) begin
            stream_cnt = 3'($urandom_range(1, 4));
            rw_check(2'(i), 13'(10 + $urandom_range(0, 50)), i[0]);
        end
        // soft reset brings msb order back
        frame(1'h0, 2'h0, ADDR_PORT_CFG, 32'h24, 1'h0, rx);
        check(32'(lsb_first), 32'h0);
        lsb_mode = 1'h0;
        // a second reset mid-run drops the applied index bytes
        rst <= 1'h1;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        check(32'(act_index), 32'h0F0F);
        rw_check(2'h1, 13'h0020, 1'h1);
        report_and_stop();
    end
endmodule

// File: hdl/twcsp_dev.sv
`timescale 1ns/1ps
module twcsp_dev
    import twcsp_pkg::*;
#(
    // arbitrary neutral identity value
    parameter logic [7:0] CHIP_ID_VAL = 8'h5A
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // serial link
    twcsp_if.dev link,
    // register space view
    output logic lsb_first,
    output logic [15:0] act_index,
    output logic wr_stb,
    output logic [12:0] wr_addr,
    output logic [7:0] wr_data
);

    ////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [0:0] {D_INSTR, D_DATA} twcsp_dst_t;
    typedef logic [MEM_DEPTH-1:0][7:0] twcsp_mem_t;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] csn_s;
        logic [1:0] sdi_s;
        twcsp_dst_t st;
        logic [3:0] bitn;
        logic [15:0] instr;
        logic rw;
        logic stream;
        logic [1:0] rem;
        logic [12:0] addr;
        logic [7:0] rx;
        logic [7:0] tx;
        logic sdo;
        logic oe;
        twcsp_mem_t mem;
        logic [15:0] idx_act;
        logic wr_stb;
        logic [12:0] wr_addr;
        logic [7:0] wr_data;
    } twcsp_dev_t;

    twcsp_dev_t q;
    twcsp_dev_t n;

    ////////////////////////////////////////////////////////////////
    // helpers
    // defaults of the byte space, shared by reset and soft reset
    function automatic twcsp_mem_t mem_dflt();
        twcsp_mem_t m;
        m = '0;
        m[ADDR_PORT_CFG[MEM_AW-1:0]] = PORT_CFG_RST;
        m[ADDR_INDEX_2[MEM_AW-1:0]] = INDEX_RST;
        m[ADDR_INDEX_1[MEM_AW-1:0]] = INDEX_RST;
        return m;
    endfunction

    // readback mux; unbacked addresses read zero
    function automatic logic [7:0] rd_byte(input twcsp_mem_t m, input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_CHIP_ID) begin
            v = CHIP_ID_VAL;
        end else if (a[12:MEM_AW] == '0) begin
            v = m[a[MEM_AW-1:0]];
        end
        return v;
    endfunction

    function automatic twcsp_dev_t reset_state();
        twcsp_dev_t r;
        r = '0;
        r.sclk_s = 3'h0;
        r.csn_s = 3'h7;
        r.st = D_INSTR;
        r.mem = mem_dflt();
        r.idx_act = {INDEX_RST, INDEX_RST};
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////
    // next state
    logic rise;
    logic fall;
    logic csn;
    logic csn_fall;
    logic lsb;
    logic bit_in;
    logic [15:0] instr_nx;
    logic [7:0] rx_nx;
    logic [12:0] addr_nx;
    logic [1:0] len;

    // either nibble copy sets the order, so a shifted write still lands
    assign lsb = q.mem[0][CFG_LSB_HI] | q.mem[0][CFG_LSB_LO];

    always_comb begin
        n = q;
        instr_nx = 16'h0000;
        rx_nx = 8'h00;
        addr_nx = 13'h0000;
        len = 2'h0;
        // pins pass two flops; stage one feeds stage two only
        n.sclk_s = {q.sclk_s[1:0], link.sclk};
        n.csn_s = {q.csn_s[1:0], link.chip_select_n};
        n.sdi_s = {q.sdi_s[0], link.sdio};
        rise = q.sclk_s[1] & ~q.sclk_s[2];
        fall = ~q.sclk_s[1] & q.sclk_s[2];
        csn = q.csn_s[1];
        csn_fall = ~q.csn_s[1] & q.csn_s[2];
        bit_in = q.sdi_s[1];
        n.wr_stb = 1'h0;
        if (csn) begin
            // deselected: edges are ignored, line released
            n.oe = 1'h0;
            if (q.bitn[2:0] != 3'h0) begin
                // partial byte: drop the frame
                n.st = D_INSTR;
                n.bitn = 4'h0;
            end else if (q.st == D_DATA && q.stream) begin
                // a stream ends only by deselect
                n.st = D_INSTR;
                n.bitn = 4'h0;
            end
            // otherwise the frame position is held for a stall
        end else begin
            if (rise && q.st == D_INSTR) begin
                // bits taken on the rising edge only
                instr_nx = lsb ? {bit_in, q.instr[15:1]} : {q.instr[14:0], bit_in};
                n.instr = instr_nx;
                n.bitn = q.bitn + 4'h1;
                if (q.bitn == 4'(INSTR_BITS - 1)) begin
                    // instruction complete, decode it
                    len = {instr_nx[LEN_HI_POS], instr_nx[LEN_LO_POS]};
                    n.st = D_DATA;
                    n.bitn = 4'h0;
                    n.rw = instr_nx[RW_POS];
                    n.stream = (len == LEN_STREAM);
                    n.rem = len;
                    n.addr = instr_nx[ADDR_W-1:0];
                    n.tx = rd_byte(q.mem, instr_nx[ADDR_W-1:0]);
                end
            end else if (rise) begin
                rx_nx = lsb ? {bit_in, q.rx[7:1]} : {q.rx[6:0], bit_in};
                n.rx = rx_nx;
                n.bitn = q.bitn + 4'h1;
                if (q.bitn == 4'h7) begin
                    n.bitn = 4'h0;
                    // next address: down in msb order, up in lsb order
                    addr_nx = lsb ? q.addr + 13'h0001 : q.addr - 13'h0001;
                    n.addr = addr_nx;
                    n.tx = rd_byte(q.mem, addr_nx);
                    if (!q.rw) begin
                        n.wr_stb = 1'h1;
                        n.wr_addr = q.addr;
                        n.wr_data = rx_nx;
                        if (q.addr == ADDR_PORT_CFG &&
                            (rx_nx[CFG_SRST_HI] | rx_nx[CFG_SRST_LO])) begin
                            // soft reset restores defaults and clears itself
                            n.mem = mem_dflt();
                        end else if (q.addr == ADDR_XFER) begin
                            // shadows move to the live copy on the transfer bit
                            if (rx_nx[XFER_POS]) begin
                                n.idx_act = {q.mem[ADDR_INDEX_2[MEM_AW-1:0]],
                                             q.mem[ADDR_INDEX_1[MEM_AW-1:0]]};
                            end
                        end else if (q.addr != ADDR_CHIP_ID && q.addr[12:MEM_AW] == '0) begin
                            n.mem[q.addr[MEM_AW-1:0]] = rx_nx;
                        end
                    end
                    if (!q.stream && q.rem == 2'h0) begin
                        // last byte of a short frame
                        n.st = D_INSTR;
                        n.oe = 1'h0;
                    end else if (!q.stream) begin
                        n.rem = q.rem - 2'h1;
                    end
                end
            end
            // readback bits leave after a fall; a resume after a stall
            // drives at once since no fall precedes the next rise
            if (q.st == D_DATA && q.rw && (fall || (csn_fall && q.bitn == 4'h0))) begin
                n.oe = 1'h1;
                n.sdo = lsb ? q.tx[0] : q.tx[7];
                n.tx = lsb ? {1'h0, q.tx[7:1]} : {q.tx[6:0], 1'h0};
            end
        end
        if (rst) begin
            n = reset_state();
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk) begin
        q <= n;
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign link.sdio_dev_o = q.sdo;
    assign link.sdio_dev_oe = q.oe;
    assign lsb_first = lsb;
    assign act_index = q.idx_act;
    assign wr_stb = q.wr_stb;
    assign wr_addr = q.wr_addr;
    assign wr_data = q.wr_data;

endmodule

// File: hdl/twcsp_host.sv
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module twcsp_host
    import twcsp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial link
    twcsp_if.host link
);

    ////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [1:0] {H_IDLE, H_RUN, H_STALL} twcsp_hst_t;

    typedef struct packed {
        logic [1:0] sdi_s;
        logic rd;
        logic [1:0] len;
        logic stall;
        logic lsb;
        logic [12:0] addr;
        logic [2:0] count;
        logic [31:0] txd;
        logic [31:0] rxd;
        logic busy;
        logic done;
        twcsp_hst_t st;
        logic [7:0] div;
        logic sclk;
        logic csn;
        logic [15:0] sh;
        logic [7:0] rx;
        logic [3:0] bitn;
        logic inst;
        logic [2:0] byt;
        logic [2:0] nbytes;
        logic last;
        logic oe;
        logic so;
        logic [31:0] prdata;
    } twcsp_host_t;

    twcsp_host_t q;
    twcsp_host_t n;

    logic wr_en;
    logic [15:0] instr;
    logic [7:0] txb;
    logic [7:0] rx_nx;

    ////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        n = q;
        instr = {q.rd, q.len, q.addr};
        txb = 8'h00;
        rx_nx = 8'h00;
        n.sdi_s = {q.sdi_s[0], link.sdio};
        wr_en = psel & penable & pwrite;
        // read data captured in the setup cycle, shown in access
        if (psel && !penable) begin
            case (paddr)
                HREG_CTRL: n.prdata = {26'h0, q.lsb, q.stall, q.len, q.rd, 1'h0};
                HREG_ADDR: n.prdata = {19'h0, q.addr};
                HREG_COUNT: n.prdata = {29'h0, q.count};
                HREG_TXD: n.prdata = q.txd;
                HREG_RXD: n.prdata = q.rxd;
                HREG_STATUS: n.prdata = {30'h0, q.done, q.busy};
                default: n.prdata = 32'h0;
            endcase
        end
        // settings are frozen while a frame runs
        if (wr_en && !q.busy) begin
            case (paddr)
                HREG_ADDR: n.addr = pwdata[12:0];
                HREG_COUNT: n.count = pwdata[2:0];
                HREG_TXD: n.txd = pwdata;
                HREG_CTRL: begin
                    n.rd = pwdata[CTRL_READ];
                    n.len = pwdata[CTRL_LEN_LO +: 2];
                    n.stall = pwdata[CTRL_STALL];
                    n.lsb = pwdata[CTRL_LSB];
                    if (pwdata[CTRL_START]) begin
                        instr = {pwdata[CTRL_READ], pwdata[CTRL_LEN_LO +: 2], q.addr};
                        n.busy = 1'h1;
                        n.done = 1'h0;
                        n.st = H_RUN;
                        n.div = 8'h00;
                        n.sclk = 1'h0;
                        n.csn = 1'h0;
                        n.sh = instr;
                        n.so = pwdata[CTRL_LSB] ? instr[0] : instr[15];
                        n.oe = 1'h1;
                        n.inst = 1'h1;
                        n.bitn = 4'h0;
                        n.byt = 3'h0;
                        n.last = 1'h0;
                        n.rxd = 32'h0;
                        // streams send count bytes, one to four
                        if (pwdata[CTRL_LEN_LO +: 2] == LEN_STREAM) begin
                            n.nbytes = (q.count == 3'h0) ? 3'h1 :
                                (q.count > 3'(STREAM_MAX)) ? 3'(STREAM_MAX) : q.count;
                        end else begin
                            n.nbytes = {1'h0, pwdata[CTRL_LEN_LO +: 2]} + 3'h1;
                        end
                    end
                end
                default: ;
            endcase
        end
        case (q.st)
            H_IDLE: ;
            H_RUN: begin
                n.div = q.div + 8'h01;
                if (q.div == 8'(HALF_CYC - 1)) begin
                    n.div = 8'h00;
                    n.sclk = ~q.sclk;
                    if (!q.sclk) begin
                        // rising edge: consume a bit, take readback
                        n.sh = q.lsb ? {1'h0, q.sh[15:1]} : {q.sh[14:0], 1'h0};
                        rx_nx = q.lsb ? {q.sdi_s[1], q.rx[7:1]} : {q.rx[6:0], q.sdi_s[1]};
                        n.rx = rx_nx;
                        n.bitn = q.bitn + 4'h1;
                        if ((q.inst && q.bitn == 4'(INSTR_BITS - 1)) ||
                            (!q.inst && q.bitn == 4'h7)) begin
                            n.bitn = 4'h0;
                            n.inst = 1'h0;
                            txb = 8'(q.txd >> {q.byt, 3'h0});
                            if (!q.inst) begin
                                n.rxd = q.rxd | ({24'h0, rx_nx} << {q.byt, 3'h0});
                                n.byt = q.byt + 3'h1;
                                n.last = (q.byt + 3'h1 == q.nbytes);
                                txb = 8'(q.txd >> {q.byt + 3'h1, 3'h0});
                            end
                            n.sh = q.lsb ? {8'h00, txb} : {txb, 8'h00};
                        end
                    end else if (q.last) begin
                        // end of frame, select rises with clock low
                        n.csn = 1'h1;
                        n.oe = 1'h0;
                        n.st = H_IDLE;
                        n.busy = 1'h0;
                        n.done = 1'h1;
                    end else if (q.stall && q.bitn == 4'h0 && q.len != LEN_STREAM) begin
                        // only whole bytes may be stalled
                        n.csn = 1'h1;
                        n.oe = 1'h0;
                        n.st = H_STALL;
                    end else begin
                        // falling edge: next bit, release line for readback
                        n.so = q.lsb ? q.sh[0] : q.sh[15];
                        n.oe = ~(q.rd & ~q.inst);
                    end
                end
            end
            H_STALL: begin
                n.div = q.div + 8'h01;
                if (q.div == 8'(STALL_CYC - 1)) begin
                    n.div = 8'h00;
                    n.csn = 1'h0;
                    n.st = H_RUN;
                    n.so = q.lsb ? q.sh[0] : q.sh[15];
                    n.oe = ~(q.rd & ~q.inst);
                end
            end
            default: n.st = H_IDLE;
        endcase
        if (rst) begin
            n = '0;
            n.csn = 1'h1;
            n.st = H_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk) begin
        q <= n;
    end

    ////////////////////////////////////////////////////////////////
    // outputs; zero-wait slave
    assign prdata = q.prdata;
    assign pready = 1'h1;
    assign pslverr = 1'h0;
    assign link.sclk = q.sclk;
    assign link.chip_select_n = q.csn;
    assign link.sdio_host_o = q.so;
    assign link.sdio_host_oe = q.oe;

endmodule

// File: hdl/twcsp_if.sv
`timescale 1ns/1ps
interface twcsp_if;
    logic sclk;
    logic chip_select_n;
    logic sdio_host_o;
    logic sdio_host_oe;
    logic sdio_dev_o;
    logic sdio_dev_oe;
    logic sdio;
    // resolved data wire; pull-down when nobody drives
    assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'h0);
    modport host (
        output sclk, chip_select_n, sdio_host_o, sdio_host_oe,
        input sdio
    );
    modport dev (
        input sclk, chip_select_n, sdio,
        output sdio_dev_o, sdio_dev_oe
    );
endinterface

// File: hdl/twcsp_pkg.sv
package twcsp_pkg;
    ////////////////////////////////////////////////////////////////
    // instruction word layout
    localparam int INSTR_BITS = 16;
    localparam int RW_POS = 15;
    localparam int LEN_HI_POS = 14;
    localparam int LEN_LO_POS = 13;
    localparam int ADDR_W = 13;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    ////////////////////////////////////////////////////////////////
    // device register space
    localparam int MEM_DEPTH = 64;
    localparam int MEM_AW = 6;
    localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
    localparam logic [12:0] ADDR_CHIP_ID = 13'h0001;
    localparam logic [12:0] ADDR_INDEX_2 = 13'h0004;
    localparam logic [12:0] ADDR_INDEX_1 = 13'h0005;
    localparam logic [12:0] ADDR_XFER = 13'h00FF;
    localparam logic [7:0] PORT_CFG_RST = 8'h18;
    localparam logic [7:0] INDEX_RST = 8'h0F;
    localparam int CFG_LSB_HI = 6;
    localparam int CFG_LSB_LO = 1;
    localparam int CFG_SRST_HI = 5;
    localparam int CFG_SRST_LO = 2;
    localparam int XFER_POS = 0;
    ////////////////////////////////////////////////////////////////
    // host apb map
    localparam logic [7:0] HREG_CTRL = 8'h00;
    localparam logic [7:0] HREG_ADDR = 8'h04;
    localparam logic [7:0] HREG_COUNT = 8'h08;
    localparam logic [7:0] HREG_TXD = 8'h0C;
    localparam logic [7:0] HREG_RXD = 8'h10;
    localparam logic [7:0] HREG_STATUS = 8'h14;
    localparam int CTRL_START = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_LEN_LO = 2;
    localparam int CTRL_STALL = 4;
    localparam int CTRL_LSB = 5;
    localparam int STREAM_MAX = 4;
    ////////////////////////////////////////////////////////////////
    // timing
    localparam int MCLK_MHZ = 250;
    localparam int SCLK_MIN_NS = 40;
    localparam int SCLK_PERIOD_NS = 80;
    localparam int HALF_CYC = SCLK_PERIOD_NS * MCLK_MHZ / 2000;
    localparam int STALL_NS = 200;
    localparam int STALL_CYC = (STALL_NS * MCLK_MHZ + 999) / 1000;
endpackage
